// ===== verilog/msc_consts.svh
// Register map, field positions and reset values of the measurement timer
// What this block does
// - 4-bit code picks counting clock source
// - Only oscillator clock codes run in sleep
// - Window codes 0-8: pin, oscillators, timers
// - Window codes 9-23: PWM, comparators, cells
// - Signal codes 0-6: pin, timers, capture
// - Signal codes 7-20: PWM, oscillator, comparators
// - 24-bit counter, read/write, reset clears
// - Counter reached through three byte views
// - Capture event copies counter into period
// - Captured period kept across every reset
// - Captured period read through byte views
// - Fixed register indices for each register
// - Period load raises the acquired flag
// - Manual update copies, then self-clears
// - Count edge chosen by clock polarity bit
// - Window polarity picks active window edge
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH
// ==========================================================
// Register indices, byte address is four times the index
`define MSC_IDX_CNT_L 16'h0300
`define MSC_IDX_CNT_H 16'h0301
`define MSC_IDX_CNT_U 16'h0302
`define MSC_IDX_PER_L 16'h0303
`define MSC_IDX_PER_H 16'h0304
`define MSC_IDX_PER_U 16'h0305
`define MSC_IDX_CTRL 16'h030C
`define MSC_IDX_STAT 16'h030E
`define MSC_IDX_CLK 16'h030F
`define MSC_IDX_SIG 16'h0310
`define MSC_IDX_WIN 16'h0311
`define MSC_IDX_FLAG 16'h0312
// ==========================================================
// Field positions
`define MSC_CTRL_EN 7
`define MSC_CTRL_WIN_POLARITY 4
`define MSC_CTRL_SPOL 3
`define MSC_CTRL_COUNT_EDGE 2
`define MSC_CTRL_GATE 0
`define MSC_STAT_UPD 7
`define MSC_FLAG_PRA 0
// ==========================================================
// Reset values and selector limits
`define MSC_RST_CNT 24'h00_0000
`define MSC_RST_BYTE 8'h00
`define MSC_CLK_LAST 4'h8
`define MSC_CLK_SLP_LO 4'h2
`define MSC_CLK_SLP_HI 4'h7
`define MSC_WIN_LAST 5'h17
`define MSC_WIN_SLP_LO 5'h01
`define MSC_WIN_SLP_HI 5'h04
`define MSC_SIG_LAST 5'h14
`endif

// ===== verilog/msc_pkg.sv
// Types shared by the measurement timer files
package msc_pkg;
	typedef logic [23:0] msc_count_t;
	typedef logic [3:0] msc_clk_code_t;
	typedef logic [4:0] msc_sel_code_t;
	typedef enum logic [1:0] {
		MSC_RESP_OKAY = 2'b00,
		MSC_RESP_SLVERR = 2'b10
	} msc_resp_t;
endpackage

// ===== verilog/msc_src_sel.sv
// Source selectors for counting clock, window and signal inputs
`timescale 1ns/10ps
`default_nettype none
`include "msc_consts.svh"
module msc_src_sel (
	input wire msc_pkg::msc_clk_code_t i_clk_code,
	input wire msc_pkg::msc_sel_code_t i_win_code,
	input wire msc_pkg::msc_sel_code_t i_sig_code,
	input wire logic i_sleep,
	input wire logic [8:0] i_clk_srcs,
	input wire logic [23:0] i_win_srcs,
	input wire logic [20:0] i_sig_srcs,
	output logic o_clk,
	output logic o_win,
	output logic o_sig
);
	// Clock: 0 instr, 1 sys, 2 hf, 3 lf, 4 500k, 5 32k, 6 sec, 7 ext, 8 ref
	wire clk_ok = (i_clk_code <= `MSC_CLK_LAST);
	wire clk_slp = (i_clk_code >= `MSC_CLK_SLP_LO) &&
		(i_clk_code <= `MSC_CLK_SLP_HI);
	wire clk_raw = clk_ok & i_clk_srcs[i_clk_code];
	assign o_clk = clk_raw & (~i_sleep | clk_slp);

	// Window: 0 pin, 1-4 oscillators, 5 ref, 6-8 timers, 9 capture,
	// 10-15 PWM, 16 osc, 17-18 comparators, 19 zero cross, 20-23 cells
	wire win_ok = (i_win_code <= `MSC_WIN_LAST);
	wire win_slp = (i_win_code >= `MSC_WIN_SLP_LO) &&
		(i_win_code <= `MSC_WIN_SLP_HI);
	wire win_raw = win_ok & i_win_srcs[i_win_code];
	assign o_win = win_raw & (~i_sleep | win_slp);

	// Signal: 0 pin, 1-5 timers, 6 capture, 7-12 PWM, 13 osc,
	// 14-15 comparators, 16 zero cross, 17-20 cells
	wire sig_ok = (i_sig_code <= `MSC_SIG_LAST);
	wire sig_raw = sig_ok & i_sig_srcs[i_sig_code];
	assign o_sig = sig_raw & ~i_sleep;
endmodule // msc_src_sel
`default_nettype wire

// ===== verilog/msc_top.sv
// Measurement timer: source selection, 24-bit counter, period capture
`timescale 1ns/10ps
`default_nettype none
`include "msc_consts.svh"
module msc_top (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_clk_en,
	input wire logic [11:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [11:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_sleep,
	input wire logic [8:0] i_clk_srcs,
	input wire logic [23:0] i_win_srcs,
	input wire logic [20:0] i_sig_srcs,
	output logic o_period_acquired_flag
);
	// ==========================================================
	// Helpers
	function automatic logic hit(input logic [11:0] a,
		input logic [15:0] idx);
		return a[11:2] == idx[9:0];
	endfunction

	function automatic logic [7:0] upd(input logic we,
		input logic [7:0] wd, input logic [7:0] old);
		return we ? wd : old;
	endfunction

	// ==========================================================
	// State
	msc_pkg::msc_count_t count_value_reg;
	msc_pkg::msc_count_t count_value_next;
	msc_pkg::msc_count_t captured_period_reg;
	logic [7:0] ctrl_reg;
	msc_pkg::msc_clk_code_t clock_source_code_reg;
	msc_pkg::msc_sel_code_t window_source_code_reg;
	msc_pkg::msc_sel_code_t signal_source_code_reg;
	logic manual_period_update_reg;
	logic manual_period_update_next;
	logic period_acquired_flag_reg;
	logic period_acquired_flag_next;
	logic clk_prev_reg;
	logic win_prev_reg;
	logic bvalid_reg;
	msc_pkg::msc_resp_t bresp_reg;
	logic rvalid_reg;
	msc_pkg::msc_resp_t rresp_reg;
	logic [31:0] rdata_reg;
	logic sel_clk;
	logic sel_win;
	logic sel_sig;

	msc_src_sel u_sel (
		.i_clk_code(clock_source_code_reg),
		.i_win_code(window_source_code_reg),
		.i_sig_code(signal_source_code_reg),
		.i_sleep(i_sleep),
		.i_clk_srcs(i_clk_srcs),
		.i_win_srcs(i_win_srcs),
		.i_sig_srcs(i_sig_srcs),
		.o_clk(sel_clk),
		.o_win(sel_win),
		.o_sig(sel_sig)
	);

	// ==========================================================
	// Write channel: address and data taken together
	wire wr_go = i_clk_en & i_awvalid & i_wvalid & ~bvalid_reg;
	assign o_awready = wr_go;
	assign o_wready = wr_go;
	wire wr_lane = wr_go & i_wstrb[0];
	wire [7:0] wd = i_wdata[7:0];
	wire wr_cnt_l = wr_lane & hit(i_awaddr, `MSC_IDX_CNT_L);
	wire wr_cnt_h = wr_lane & hit(i_awaddr, `MSC_IDX_CNT_H);
	wire wr_cnt_u = wr_lane & hit(i_awaddr, `MSC_IDX_CNT_U);
	wire wr_ctrl = wr_lane & hit(i_awaddr, `MSC_IDX_CTRL);
	wire wr_stat = wr_lane & hit(i_awaddr, `MSC_IDX_STAT);
	wire wr_clk = wr_lane & hit(i_awaddr, `MSC_IDX_CLK);
	wire wr_sig = wr_lane & hit(i_awaddr, `MSC_IDX_SIG);
	wire wr_win = wr_lane & hit(i_awaddr, `MSC_IDX_WIN);
	wire wr_flag = wr_lane & hit(i_awaddr, `MSC_IDX_FLAG);
	wire wr_per = hit(i_awaddr, `MSC_IDX_PER_L) |
		hit(i_awaddr, `MSC_IDX_PER_H) | hit(i_awaddr, `MSC_IDX_PER_U);
	wire wr_mapped = hit(i_awaddr, `MSC_IDX_CNT_L) |
		hit(i_awaddr, `MSC_IDX_CNT_H) | hit(i_awaddr, `MSC_IDX_CNT_U) |
		hit(i_awaddr, `MSC_IDX_CTRL) | hit(i_awaddr, `MSC_IDX_STAT) |
		hit(i_awaddr, `MSC_IDX_CLK) | hit(i_awaddr, `MSC_IDX_SIG) |
		hit(i_awaddr, `MSC_IDX_WIN) | hit(i_awaddr, `MSC_IDX_FLAG);
	// Captured period is read only, so a write there is an error
	wire msc_pkg::msc_resp_t wr_resp = (wr_mapped & ~wr_per) ?
		msc_pkg::MSC_RESP_OKAY : msc_pkg::MSC_RESP_SLVERR;

	// ==========================================================
	// Read channel
	wire rd_go = i_clk_en & i_arvalid & ~rvalid_reg;
	assign o_arready = rd_go;
	wire [7:0] stat_byte = {manual_period_update_reg, 3'b000,
		ctrl_reg[`MSC_CTRL_EN], sel_clk, sel_win, sel_sig};
	wire [8:0] rd_sel =
		hit(i_araddr, `MSC_IDX_CNT_L) ? {1'b1, count_value_reg[7:0]} :
		hit(i_araddr, `MSC_IDX_CNT_H) ? {1'b1, count_value_reg[15:8]} :
		hit(i_araddr, `MSC_IDX_CNT_U) ? {1'b1, count_value_reg[23:16]} :
		hit(i_araddr, `MSC_IDX_PER_L) ?
			{1'b1, captured_period_reg[7:0]} :
		hit(i_araddr, `MSC_IDX_PER_H) ?
			{1'b1, captured_period_reg[15:8]} :
		hit(i_araddr, `MSC_IDX_PER_U) ?
			{1'b1, captured_period_reg[23:16]} :
		hit(i_araddr, `MSC_IDX_CTRL) ? {1'b1, ctrl_reg} :
		hit(i_araddr, `MSC_IDX_STAT) ? {1'b1, stat_byte} :
		hit(i_araddr, `MSC_IDX_CLK) ?
			{5'b1_0000, clock_source_code_reg} :
		hit(i_araddr, `MSC_IDX_SIG) ?
			{4'b1_000, signal_source_code_reg} :
		hit(i_araddr, `MSC_IDX_WIN) ?
			{4'b1_000, window_source_code_reg} :
		hit(i_araddr, `MSC_IDX_FLAG) ?
			{8'b1000_0000, period_acquired_flag_reg} :
		9'h000;

	// ==========================================================
	// Counting and capture
	wire cnt_en = ctrl_reg[`MSC_CTRL_EN];
	wire count_edge_polarity = ctrl_reg[`MSC_CTRL_COUNT_EDGE];
	wire window_polarity = ctrl_reg[`MSC_CTRL_WIN_POLARITY];
	wire clk_edge = count_edge_polarity ? (clk_prev_reg & ~sel_clk) :
		(sel_clk & ~clk_prev_reg);
	wire sig_active = sel_sig ^ ctrl_reg[`MSC_CTRL_SPOL];
	wire count_inc = cnt_en & clk_edge &
		(~ctrl_reg[`MSC_CTRL_GATE] | sig_active);
	wire win_edge = window_polarity ? (win_prev_reg & ~sel_win) :
		(sel_win & ~win_prev_reg);
	wire capture = (cnt_en & win_edge) | manual_period_update_reg;
	wire msc_pkg::msc_count_t count_plus =
		count_inc ? 24'(count_value_reg + 24'h00_0001) : count_value_reg;

	// Software byte writes win over the increment in the same cycle
	assign count_value_next = {
		upd(wr_cnt_u, wd, count_plus[23:16]),
		upd(wr_cnt_h, wd, count_plus[15:8]),
		upd(wr_cnt_l, wd, count_plus[7:0])};

	// The request stands one cycle, during which the copy is made
	assign manual_period_update_next = (wr_stat & wd[`MSC_STAT_UPD]) ? 1'b1 :
		1'b0;
	// Hardware set wins over a clear written in the same cycle
	assign period_acquired_flag_next = capture ? 1'b1 :
		(wr_flag & wd[`MSC_FLAG_PRA]) ? 1'b0 :
		period_acquired_flag_reg;

	// ==========================================================
	// Registers
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			count_value_reg <= `MSC_RST_CNT;
			ctrl_reg <= `MSC_RST_BYTE;
			clock_source_code_reg <= 4'h0;
			window_source_code_reg <= 5'h00;
			signal_source_code_reg <= 5'h00;
			manual_period_update_reg <= 1'b0;
			period_acquired_flag_reg <= 1'b0;
			clk_prev_reg <= 1'b0;
			win_prev_reg <= 1'b0;
		end else if (i_clk_en) begin
			count_value_reg <= count_value_next;
			ctrl_reg <= upd(wr_ctrl, wd, ctrl_reg);
			if (wr_clk) begin
				clock_source_code_reg <= wd[3:0];
			end
			if (wr_win) begin
				window_source_code_reg <= wd[4:0];
			end
			if (wr_sig) begin
				signal_source_code_reg <= wd[4:0];
			end
			manual_period_update_reg <= manual_period_update_next;
			period_acquired_flag_reg <= period_acquired_flag_next;
			clk_prev_reg <= sel_clk;
			win_prev_reg <= sel_win;
		end
	end

	// No reset: contents survive every reset
	always_ff @(posedge i_clock) begin
		if (i_clk_en && capture) begin
			captured_period_reg <= count_value_reg;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= msc_pkg::MSC_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= msc_pkg::MSC_RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
		end else if (i_clk_en) begin
			if (wr_go) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_resp;
			end else if (i_bready) begin
				bvalid_reg <= 1'b0;
			end
			if (rd_go) begin
				rvalid_reg <= 1'b1;
				rdata_reg <= {24'h00_0000, rd_sel[7:0]};
				rresp_reg <= rd_sel[8] ? msc_pkg::MSC_RESP_OKAY :
					msc_pkg::MSC_RESP_SLVERR;
			end else if (i_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	assign o_bvalid = bvalid_reg;
	assign o_bresp = bresp_reg;
	assign o_rvalid = rvalid_reg;
	assign o_rresp = rresp_reg;
	assign o_rdata = rdata_reg;
	assign o_period_acquired_flag = period_acquired_flag_reg;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	sequence s_manual_req;
		i_clk_en && wr_stat && wd[`MSC_STAT_UPD];
	endsequence

	sequence s_manual_done;
		i_clk_en && manual_period_update_reg
			&& !(wr_stat && wd[`MSC_STAT_UPD]);
	endsequence

	AST_CAPTURE_COPY: assert property (
		(i_clk_en && capture) |=>
			captured_period_reg == $past(count_value_reg))
		else $error("period not copied from counter");

	AST_FLAG_RAISE: assert property (
		(i_clk_en && capture) |=> period_acquired_flag_reg)
		else $error("acquired flag not raised on capture");

	AST_MANUAL_SEQ: assert property (
		s_manual_req ##1 s_manual_done |=>
			!manual_period_update_reg &&
			captured_period_reg == $past(count_value_reg))
		else $error("manual update did not copy and clear");

	AST_COUNT_EDGE: assert property (
		(i_clk_en && cnt_en && !ctrl_reg[`MSC_CTRL_GATE] &&
			!wr_cnt_l && !wr_cnt_h && !wr_cnt_u &&
			(count_edge_polarity ? (clk_prev_reg && !sel_clk) :
			(!clk_prev_reg && sel_clk))) |=>
			count_value_reg == 24'($past(count_value_reg) + 24'h00_0001))
		else $error("counter missed the selected clock edge");

	AST_CLK_RESERVED: assert property (
		(clock_source_code_reg > `MSC_CLK_LAST) |-> !sel_clk)
		else $error("reserved clock code passed a source");

	AST_CLK_SLEEP: assert property (
		(i_sleep && (clock_source_code_reg < `MSC_CLK_SLP_LO ||
			clock_source_code_reg > `MSC_CLK_SLP_HI)) |-> !sel_clk)
		else $error("non-sleep clock running in sleep");

	AST_WIN_SLEEP: assert property (
		(i_sleep && (window_source_code_reg < `MSC_WIN_SLP_LO ||
			window_source_code_reg > `MSC_WIN_SLP_HI)) |-> !sel_win)
		else $error("non-sleep window source active in sleep");

	AST_RESET_CLEAR: assert property (
		$fell(i_rst) |-> count_value_reg == `MSC_RST_CNT)
		else $error("counter not zero after reset");

	AST_BYTE_WRITE: assert property (
		(i_clk_en && wr_cnt_h) |=> count_value_reg[15:8] == $past(wd))
		else $error("high byte write not applied");

	AST_WIN_CAPTURE: assert property (
		(i_clk_en && cnt_en && !window_polarity && sel_win && !win_prev_reg) |=>
			period_acquired_flag_reg)
		else $error("rising window edge did not capture");

	AST_MANUAL_CLEAR: assert property (
		s_manual_done |=> !manual_period_update_reg)
		else $error("manual update request not cleared");

	AST_FLAG_SOURCE: assert property (
		$rose(period_acquired_flag_reg) |-> $past(capture))
		else $error("acquired flag rose without a capture");

	AST_WIN_FALL: assert property (
		(i_clk_en && cnt_en && window_polarity && !sel_win &&
			win_prev_reg) |=> period_acquired_flag_reg)
		else $error("falling window edge did not capture");

	AST_WIN_RESERVED: assert property (
		(window_source_code_reg > `MSC_WIN_LAST) |-> !sel_win)
		else $error("reserved window code passed a source");

	AST_SIG_RESERVED: assert property (
		(signal_source_code_reg > `MSC_SIG_LAST) |-> !sel_sig)
		else $error("reserved signal code passed a source");

	AST_COUNT_HOLD: assert property (
		(i_clk_en && !cnt_en && !wr_cnt_l && !wr_cnt_h && !wr_cnt_u) |=>
			count_value_reg == $past(count_value_reg))
		else $error("disabled counter changed");

	AST_FREEZE: assert property (
		!i_clk_en |=> count_value_reg == $past(count_value_reg) &&
			period_acquired_flag_reg == $past(period_acquired_flag_reg))
		else $error("state changed while clock enable low");

	AST_PERIOD_RO: assert property (
		(wr_go && wr_per) |=> o_bresp == msc_pkg::MSC_RESP_SLVERR)
		else $error("write to captured period not refused");

	AST_WR_ANSWER: assert property (
		wr_go |=> o_bvalid)
		else $error("write response missing");

	AST_RD_ANSWER: assert property (
		rd_go |=> o_rvalid)
		else $error("read data missing");
endmodule // msc_top
`default_nettype wire

// ===== sim/msc_src_model.sv
// Behavioural model of the clock, window and signal sources
`timescale 1ns/10ps
`default_nettype none
module msc_src_model (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_go,
	input wire logic [3:0] i_ntog,
	input wire logic [8:0] i_clk_mask,
	input wire logic [23:0] i_win_mask,
	input wire logic i_win_lvl,
	input wire logic [20:0] i_sig_mask,
	input wire logic i_sig_lvl,
	output logic o_busy,
	output logic [8:0] o_clk_srcs,
	output logic [23:0] o_win_srcs,
	output logic [20:0] o_sig_srcs
);
	logic lvl_reg;
	logic ph_reg;
	logic [3:0] n_reg;
	// ==========================================================
	// Clock sources: each level holds two cycles so no edge is lost
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			lvl_reg <= 1'b0;
			ph_reg <= 1'b0;
			n_reg <= 4'h0;
		end else if (i_go) begin
			n_reg <= i_ntog;
		end else if (n_reg != 4'h0) begin
			ph_reg <= ~ph_reg;
			if (ph_reg) begin
				lvl_reg <= ~lvl_reg;
				n_reg <= n_reg - 4'h1;
			end
		end
	end
	assign o_busy = i_go || (n_reg != 4'h0);
	assign o_clk_srcs = i_clk_mask & {9{lvl_reg}};
	assign o_win_srcs = i_win_mask & {24{i_win_lvl}};
	assign o_sig_srcs = i_sig_mask & {21{i_sig_lvl}};
endmodule // msc_src_model
`default_nettype wire

// ===== sim/msc_top_tb.sv
// Self-checking bench of the measurement timer
`timescale 1ns/10ps
`default_nettype none
`include "msc_consts.svh"
module msc_top_tb;
	logic i_clock, i_rst, i_clk_en, i_awvalid, i_wvalid, i_bready;
	logic i_arvalid, i_rready, i_sleep, i_go, i_win_lvl, i_sig_lvl;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_flag, busy;
	logic [11:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata;
	logic [3:0] i_wstrb, i_ntog;
	logic [1:0] o_bresp, o_rresp, r;
	logic [8:0] i_clk_mask, clk_srcs;
	logic [23:0] i_win_mask, win_srcs;
	logic [20:0] i_sig_mask, sig_srcs;
	logic [7:0] d, b;
	int n_fail, num_checks, cyc;
	msc_top u_msc_top (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(i_clk_en),
		.i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
		.i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
		.o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
		.i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
		.o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
		.o_rvalid(o_rvalid), .i_rready(i_rready), .i_sleep(i_sleep),
		.i_clk_srcs(clk_srcs), .i_win_srcs(win_srcs), .i_sig_srcs(sig_srcs),
		.o_period_acquired_flag(o_flag));
	msc_src_model u_msc_src_model (.i_clock(i_clock), .i_rst(i_rst),
		.i_go(i_go), .i_ntog(i_ntog), .i_clk_mask(i_clk_mask),
		.i_win_mask(i_win_mask), .i_win_lvl(i_win_lvl),
		.i_sig_mask(i_sig_mask), .i_sig_lvl(i_sig_lvl), .o_busy(busy),
		.o_clk_srcs(clk_srcs), .o_win_srcs(win_srcs), .o_sig_srcs(sig_srcs));
	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end
	// ==========================================================
	// Bus and compare tasks
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] idx, input logic [7:0] v,
		output logic [1:0] rr);
		logic pa, pw, ta, tw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge i_clock);
		i_awaddr <= {idx[9:0], 2'b00};
		i_wdata <= {24'h00_0000, v};
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		while (pa || pw) begin
			@(negedge i_clock);
			ta = pa && (o_awready === 1'b1);
			tw = pw && (o_wready === 1'b1);
			@(posedge i_clock);
			if (ta) begin
				i_awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (tw) begin
				i_wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		do @(negedge i_clock); while (o_bvalid !== 1'b1);
		rr = o_bresp;
		@(posedge i_clock);
		i_bready <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] idx, output logic [7:0] v,
		output logic [1:0] rr);
		@(posedge i_clock);
		i_araddr <= {idx[9:0], 2'b00};
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do @(negedge i_clock); while (o_arready !== 1'b1);
		@(posedge i_clock);
		i_arvalid <= 1'b0;
		do @(negedge i_clock); while (o_rvalid !== 1'b1);
		v = o_rdata[7:0];
		rr = o_rresp;
		@(posedge i_clock);
		i_rready <= 1'b0;
	endtask
	task automatic wo(input logic [15:0] idx, input logic [7:0] v);
		logic [1:0] rr;
		wr(idx, v, rr);
		chk(rr, msc_pkg::MSC_RESP_OKAY);
	endtask
	task automatic rc(input logic [15:0] idx, input logic [7:0] e);
		logic [7:0] dd;
		logic [1:0] rr;
		rd(idx, dd, rr);
		chk(dd, e);
	endtask
	// Settle time covers source sync plus the increment latency
	task automatic tog(input logic [3:0] n);
		@(posedge i_clock);
		i_go <= 1'b1;
		i_ntog <= n;
		@(posedge i_clock);
		i_go <= 1'b0;
		do @(negedge i_clock); while (busy);
		repeat (4) @(posedge i_clock);
	endtask
	task automatic win_step(input logic l, input logic e);
		wo(`MSC_IDX_FLAG, 8'h01);
		@(posedge i_clock);
		i_win_lvl <= l;
		repeat (4) @(posedge i_clock);
		@(negedge i_clock);
		chk(o_flag, e);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_regs();
		rc(`MSC_IDX_CNT_U, 8'h00);
		chk(o_flag, 1'b0);
		wo(`MSC_IDX_CNT_L, 8'h12);
		wo(`MSC_IDX_CNT_H, 8'h34);
		wo(`MSC_IDX_CNT_U, 8'h56);
		rc(`MSC_IDX_CNT_L, 8'h12);
		rc(`MSC_IDX_CNT_H, 8'h34);
		rc(`MSC_IDX_CNT_U, 8'h56);
		wr(`MSC_IDX_PER_H, 8'hAA, r);
		chk(r, msc_pkg::MSC_RESP_SLVERR);
		wr(16'h03FF, 8'h55, r);
		chk(r, msc_pkg::MSC_RESP_SLVERR);
		rd(16'h03FF, d, r);
		chk({r, d}, {msc_pkg::MSC_RESP_SLVERR, 8'h00});
		$display("test registers done");
	endtask
	task automatic t_manual();
		wo(`MSC_IDX_STAT, 8'h80);
		rd(`MSC_IDX_STAT, d, r);
		chk(d[7], 1'b0);
		rc(`MSC_IDX_PER_L, 8'h12);
		rc(`MSC_IDX_PER_H, 8'h34);
		rc(`MSC_IDX_PER_U, 8'h56);
		chk(o_flag, 1'b1);
		@(posedge i_clock);
		i_rst <= 1'b1;
		repeat (3) @(posedge i_clock);
		i_rst <= 1'b0;
		rc(`MSC_IDX_CNT_H, 8'h00);
		rc(`MSC_IDX_PER_U, 8'h56);
		$display("test manual update done");
	endtask
	task automatic t_clk();
		logic [7:0] e;
		wo(`MSC_IDX_CTRL, 8'h80);
		for (int s = 0; s < 2; s++) begin
			for (int c = 0; c < 16; c++) begin
				wo(`MSC_IDX_CLK, 8'(c));
				@(posedge i_clock);
				i_sleep <= s[0];
				i_clk_mask <= (c < 9) ? (9'h001 << c) : 9'h1FF;
				rd(`MSC_IDX_CNT_L, b, r);
				tog(4'h4);
				e = b + ((c < 9 && (s == 0 || (c >= 2 && c <= 7))) ?
					8'h02 : 8'h00);
				rc(`MSC_IDX_CNT_L, e);
			end
		end
		@(posedge i_clock);
		i_sleep <= 1'b0;
		i_clk_mask <= 9'h002;
		wo(`MSC_IDX_CTRL, 8'h84);
		wo(`MSC_IDX_CLK, 8'h01);
		rd(`MSC_IDX_CNT_L, b, r);
		tog(4'h1);
		rc(`MSC_IDX_CNT_L, b);
		tog(4'h1);
		rc(`MSC_IDX_CNT_L, b + 8'h01);
		// Clock enable low: edges pass unseen, counter frozen
		@(posedge i_clock);
		i_clk_en <= 1'b0;
		tog(4'h2);
		@(posedge i_clock);
		i_clk_en <= 1'b1;
		rc(`MSC_IDX_CNT_L, b + 8'h01);
		// Gate on signal level: inactive blocks, inverted level opens
		wo(`MSC_IDX_CTRL, 8'h85);
		tog(4'h2);
		rc(`MSC_IDX_CNT_L, b + 8'h01);
		wo(`MSC_IDX_CTRL, 8'h8D);
		tog(4'h2);
		rc(`MSC_IDX_CNT_L, b + 8'h02);
		$display("test counting clock done");
	endtask
	task automatic t_win();
		wo(`MSC_IDX_CTRL, 8'h80);
		rd(`MSC_IDX_CNT_L, b, r);
		for (int c = 0; c < 32; c++) begin
			wo(`MSC_IDX_WIN, 8'(c));
			@(posedge i_clock);
			i_win_mask <= (c < 24) ? (24'h00_0001 << c) : 24'hFF_FFFF;
			win_step(1'b1, c < 24);
			win_step(1'b0, 1'b0);
		end
		rc(`MSC_IDX_PER_L, b);
		wo(`MSC_IDX_WIN, 8'h05);
		@(posedge i_clock);
		i_win_mask <= 24'h00_0020;
		wo(`MSC_IDX_CTRL, 8'h90);
		win_step(1'b1, 1'b0);
		win_step(1'b0, 1'b1);
		$display("test window capture done");
	endtask
	task automatic t_sig();
		for (int c = 0; c < 32; c++) begin
			wo(`MSC_IDX_SIG, 8'(c));
			@(posedge i_clock);
			i_sig_mask <= (c < 21) ? (21'h00_0001 << c) : 21'h1F_FFFF;
			i_sig_lvl <= 1'b1;
			repeat (2) @(posedge i_clock);
			rd(`MSC_IDX_STAT, d, r);
			chk(d[0], c < 21);
		end
		$display("test signal select done");
	endtask
	initial begin
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
		{i_sleep, i_go, i_win_lvl, i_sig_lvl, i_ntog} = 8'h00;
		{i_awaddr, i_araddr, i_wdata} = 56'h00_0000_0000_0000;
		{i_clk_mask, i_win_mask, i_sig_mask} = 54'h00_0000_0000_0000;
		i_wstrb = 4'h1;
		i_clk_en = 1'b1;
		i_rst = 1'b1;
		repeat (10) @(posedge i_clock);
		i_rst <= 1'b0;
		t_regs();
		t_manual();
		t_clk();
		t_win();
		t_sig();
		summarize();
	end
endmodule // msc_top_tb
`default_nettype wire
